// file: core/sisr_pkg.sv
// Constants for the supply input status register bank
package sisr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NUM_STATUS = 13;
    localparam int NUM_WARN = 3;

    localparam logic [15:0] OFS_STATUS = 16'h0000;
    localparam logic [15:0] OFS_WARN = 16'h0001;
    localparam logic [15:0] OFS_VOLTS = 16'h0002;
    localparam logic [15:0] OFS_AMPS = 16'h0003;
    localparam logic [15:0] OFS_TEMP = 16'h0004;
    localparam logic [15:0] OFS_SECS_HI = 16'h0005;
    localparam logic [15:0] OFS_SECS_LO = 16'h0006;
    localparam logic [15:0] OFS_VOLTS_ALIAS = 16'h0064;
    localparam logic [15:0] OFS_AMPS_ALIAS = 16'h0065;
    localparam logic [15:0] OFS_TEMP_ALIAS = 16'h015E;
    localparam logic [15:0] OFS_SECS_HI_ALIAS = 16'h0190;
    localparam logic [15:0] OFS_SECS_LO_ALIAS = 16'h0191;

    // Status bit positions
    localparam int BIT_REMOTE_OFF_STOP = 0;
    localparam int BIT_LOW_INPUT_STOP = 1;
    localparam int BIT_OPEN_PHASE_TRIP = 2;
    localparam int BIT_HW_OVERVOLT_TRIP = 3;
    localparam int BIT_SETPOINT_OVERVOLT_TRIP = 4;
    localparam int BIT_PRIMARY_OVERCURRENT_TRIP = 5;
    localparam int BIT_SECONDARY_OVERCURRENT_TRIP = 6;
    localparam int BIT_SUSTAINED_OVERCURRENT_TRIP = 7;
    localparam int BIT_OVERTEMP_TRIP = 8;
    localparam int BIT_FAN_FAULT_TRIP = 9;
    localparam int BIT_HALT_TRIP = 10;
    localparam int BIT_EXTERNAL_SUPPLY_STOP = 11;
    localparam int BIT_SYSTEM_FAULT_TRIP = 12;

    // Warning bit positions
    localparam int BIT_VOLTAGE_SHORTFALL_WARN = 0;
    localparam int BIT_CURRENT_SHORTFALL_WARN = 1;
    localparam int BIT_INPUT_OVERVOLT_WARN = 2;

    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_SECONDS = 32'h00000000;
    localparam logic [31:0] SECONDS_MAX = 32'h7FFFFFFF;

    // One second at the 50 MHz clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int SECOND_MS = 1000;
    localparam int TICKS_PER_SEC = SECOND_MS * 1000000 / CLK_PERIOD_NS;
endpackage : sisr_pkg

// file: core/sisr_cnt_if.sv
// Link between the register bank and its output-on seconds counter
`timescale 1ns/100ps
interface sisr_cnt_if;
    logic run;
    logic snap;
    logic [31:0] nv_init;
    logic [31:0] count;
    logic [31:0] snap_count;
    logic loaded;

    modport ctr (input run, input snap, input nv_init,
                 output count, output snap_count, output loaded);
    modport bank (output run, output snap, output nv_init,
                  input count, input snap_count, input loaded);
endinterface : sisr_cnt_if

// file: core/sisr_latch_bit.sv
// One status flag with optional protection latch
`timescale 1ns/100ps
module sisr_latch_bit #(
    parameter bit STICKY = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Cause and latch control
    input wire logic cause_i,
    input wire logic latch_en_i,
    input wire logic release_i,
    input wire logic causes_gone_i,
    // Flag
    output logic flag_o
);
    typedef struct packed {
        logic flag;
    } sisr_bit_s;

    sisr_bit_s st_q;
    sisr_bit_s st_d;

    always_comb begin
        st_d = st_q;
        if (STICKY) begin
            st_d.flag = cause_i | st_q.flag;
        end else begin
            // Cause always wins over a release in the same cycle
            st_d.flag = cause_i |
                (st_q.flag & latch_en_i & ~(release_i & causes_gone_i));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

    property p_sticky_hold;
        @(posedge clk_i) disable iff (rst_i)
        (STICKY && flag_o) |=> flag_o;
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped");

    property p_latch_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!STICKY && flag_o && latch_en_i && !release_i) |=> flag_o;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");
endmodule : sisr_latch_bit

// file: core/sisr_sec_counter.sv
// Output-on seconds counter with retained start value and read snapshot
`timescale 1ns/100ps
module sisr_sec_counter
    import sisr_pkg::*;
#(
    parameter int TICKS = sisr_pkg::TICKS_PER_SEC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    sisr_cnt_if.ctr cnt
);
    typedef struct packed {
        logic loaded;
        logic [31:0] presc;
        logic [31:0] count;
        logic [31:0] snap_count;
    } sisr_cnt_s;

    sisr_cnt_s st_q;
    sisr_cnt_s st_d;

    always_comb begin
        st_d = st_q;
        if (!st_q.loaded) begin
            // Stored value taken after reset release, never under reset
            st_d.loaded = 1'b1;
            st_d.count = cnt.nv_init;
            st_d.presc = '0;
        end else if (cnt.run) begin
            if (st_q.presc == 32'(TICKS - 1)) begin
                st_d.presc = '0;
                if (st_q.count != SECONDS_MAX) begin
                    st_d.count = st_q.count + 32'h00000001;
                end
            end else begin
                st_d.presc = st_q.presc + 32'h00000001;
            end
        end
        if (cnt.snap) begin
            st_d.snap_count = st_q.count;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '{loaded: 1'b0, presc: '0, count: RST_SECONDS, snap_count: RST_SECONDS};
        end else begin
            st_q <= st_d;
        end
    end

    assign cnt.count = st_q.count;
    assign cnt.snap_count = st_q.snap_count;
    assign cnt.loaded = st_q.loaded;

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.loaded && !cnt.run) |=> $stable(st_q.count);
    endproperty
    a_halt: assert property (p_halt) else $error("seconds advanced while stopped");

    property p_step;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.loaded && cnt.run && st_q.presc == 32'(TICKS - 1) && st_q.count != SECONDS_MAX)
        |=> st_q.count == $past(st_q.count) + 32'h00000001;
    endproperty
    a_step: assert property (p_step) else $error("seconds did not step");

    property p_load;
        @(posedge clk_i) disable iff (rst_i)
        // Release edge still shows the reset state, so wait for reset to read low
        (!rst_i && !st_q.loaded) |=> st_q.loaded && st_q.count == $past(cnt.nv_init);
    endproperty
    a_load: assert property (p_load) else $error("stored seconds not restored");

    c_second: cover property (@(posedge clk_i) disable iff (rst_i)
        cnt.run && st_q.presc == 32'(TICKS - 1));
endmodule : sisr_sec_counter

// file: core/sisr_bank.sv
// Read-only input register bank of the supply: status, warning, measures, on-time
`timescale 1ns/100ps
module sisr_bank
    import sisr_pkg::*;
#(
    parameter int TICKS = sisr_pkg::TICKS_PER_SEC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Protection and stop causes, asynchronous levels
    input wire logic [sisr_pkg::NUM_STATUS-1:0] cause_i,
    // Per-bit latch selection from the protection settings
    input wire logic [sisr_pkg::NUM_STATUS-1:0] latch_mode_i,
    // Warning causes, asynchronous levels
    input wire logic [sisr_pkg::NUM_WARN-1:0] warn_i,
    // Measurements from converter logic on this clock
    input wire logic signed [15:0] volts_i,
    input wire logic signed [15:0] amps_i,
    input wire logic signed [15:0] temp_i,
    // Retained on-time value at power up
    input wire logic [31:0] nv_seconds_i,
    // Register read port from the fieldbus framer
    input wire logic rd_req_i,
    input wire logic rd_first_i,
    input wire logic [sisr_pkg::ADDR_W-1:0] rd_addr_i,
    output logic rd_ack_o,
    output logic rd_err_o,
    output logic [sisr_pkg::DATA_W-1:0] rd_data_o,
    // Status view and value to retain across power loss
    output logic [sisr_pkg::DATA_W-1:0] status_o,
    output logic [31:0] nv_seconds_o
);
    import sisr_pkg::*;

    typedef struct packed {
        logic [NUM_STATUS-1:0] c_meta;
        logic [NUM_STATUS-1:0] c_sync;
        logic [NUM_WARN-1:0] w_meta;
        logic [NUM_WARN-1:0] w_sync;
        logic rc_prev;
        logic [15:0] volts;
        logic [15:0] amps;
        logic [15:0] temp;
        logic rd_ack;
        logic rd_err;
        logic [15:0] rd_data;
        logic [15:0] status;
        logic [31:0] nv_out;
    } sisr_bank_s;

    sisr_bank_s st_q;
    sisr_bank_s st_d;

    logic [NUM_STATUS-1:0] flags;
    logic release_pulse;
    logic causes_gone;
    logic [15:0] status_word;
    logic [15:0] warn_word;
    logic [31:0] secs_view;

    sisr_cnt_if cnt ();

    // Remote off operation releases latched protections
    assign release_pulse = st_q.c_sync[BIT_REMOTE_OFF_STOP] & ~st_q.rc_prev;
    // Remote off itself does not block its own release
    assign causes_gone = ~|st_q.c_sync[NUM_STATUS-1:1];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_STATUS; gi++) begin : g_flag
            sisr_latch_bit #(
                .STICKY(gi == BIT_EXTERNAL_SUPPLY_STOP)
            ) u_flag (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .cause_i(st_q.c_sync[gi]),
                .latch_en_i(latch_mode_i[gi]),
                .release_i(release_pulse),
                .causes_gone_i(causes_gone),
                .flag_o(flags[gi])
            );
        end
    endgenerate

    // Undefined upper bits read as zero
    assign status_word = {{(16 - NUM_STATUS){1'b0}}, flags};
    assign warn_word = {{(16 - NUM_WARN){1'b0}}, st_q.w_sync};

    // Output stopped by protection or remote off; bit 11 is a record only
    assign cnt.run = cnt.loaded & ~|(flags & ~(13'h0001 << BIT_EXTERNAL_SUPPLY_STOP));
    // First read of a transaction freezes the count for the rest of it
    assign cnt.snap = rd_req_i & rd_first_i;
    assign cnt.nv_init = nv_seconds_i;
    assign secs_view = rd_first_i ? cnt.count : cnt.snap_count;

    sisr_sec_counter #(
        .TICKS(TICKS)
    ) u_secs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cnt(cnt)
    );

    always_comb begin
        st_d = st_q;
        st_d.c_meta = cause_i;
        st_d.c_sync = st_q.c_meta;
        st_d.w_meta = warn_i;
        st_d.w_sync = st_q.w_meta;
        st_d.rc_prev = st_q.c_sync[BIT_REMOTE_OFF_STOP];
        // Passed through as measured, no clamping to the rated span
        st_d.volts = volts_i;
        st_d.amps = amps_i;
        st_d.temp = temp_i;
        st_d.status = status_word;
        st_d.nv_out = cnt.count;
        st_d.rd_ack = rd_req_i;
        st_d.rd_err = 1'b0;
        st_d.rd_data = RST_WORD;
        if (rd_req_i) begin
            case (rd_addr_i)
                OFS_STATUS: st_d.rd_data = status_word;
                OFS_WARN: st_d.rd_data = warn_word;
                OFS_VOLTS, OFS_VOLTS_ALIAS: st_d.rd_data = st_q.volts;
                OFS_AMPS, OFS_AMPS_ALIAS: st_d.rd_data = st_q.amps;
                OFS_TEMP, OFS_TEMP_ALIAS: st_d.rd_data = st_q.temp;
                OFS_SECS_HI, OFS_SECS_HI_ALIAS: st_d.rd_data = secs_view[31:16];
                OFS_SECS_LO, OFS_SECS_LO_ALIAS: st_d.rd_data = secs_view[15:0];
                default: st_d.rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '{default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_ack_o = st_q.rd_ack;
    assign rd_err_o = st_q.rd_err;
    assign rd_data_o = st_q.rd_data;
    assign status_o = st_q.status;
    assign nv_seconds_o = st_q.nv_out;

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        rd_req_i |=> rd_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("read not answered next cycle");

    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && rd_addr_i == 16'h0007) |=> rd_err_o && rd_data_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");

    property p_status_read;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && rd_addr_i == OFS_STATUS) |=> rd_data_o == $past(status_word)
            && rd_data_o[15:13] == 3'h0;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_volts_alias;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && (rd_addr_i == OFS_VOLTS || rd_addr_i == OFS_VOLTS_ALIAS))
        |=> rd_data_o == $past(st_q.volts);
    endproperty
    a_volts_alias: assert property (p_volts_alias) else $error("voltage read wrong");

    property p_temp_alias;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && rd_addr_i == OFS_TEMP_ALIAS) |=> rd_data_o == $past(st_q.temp);
    endproperty
    a_temp_alias: assert property (p_temp_alias) else $error("temperature read wrong");

    property p_clear_nolatch;
        @(posedge clk_i) disable iff (rst_i)
        (!cause_i[BIT_FAN_FAULT_TRIP] && !latch_mode_i[BIT_FAN_FAULT_TRIP]) [*4]
        |-> !flags[BIT_FAN_FAULT_TRIP];
    endproperty
    a_clear_nolatch: assert property (p_clear_nolatch) else $error("flag kept after cause");

    property p_set;
        @(posedge clk_i) disable iff (rst_i)
        cause_i[BIT_HW_OVERVOLT_TRIP] [*3] |=> flags[BIT_HW_OVERVOLT_TRIP];
    endproperty
    a_set: assert property (p_set) else $error("cause not flagged");

    property p_warn;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && rd_addr_i == OFS_WARN) |=> rd_data_o == {13'h0000, $past(st_q.w_sync)};
    endproperty
    a_warn: assert property (p_warn) else $error("warning read wrong");

    property p_coherent;
        @(posedge clk_i) disable iff (rst_i)
        (rd_req_i && !rd_first_i && rd_addr_i == OFS_SECS_LO) |=> rd_data_o ==
            $past(cnt.snap_count[15:0]);
    endproperty
    a_coherent: assert property (p_coherent) else $error("counter words torn");

    c_latch_release: cover property (@(posedge clk_i) disable iff (rst_i)
        flags[BIT_SETPOINT_OVERVOLT_TRIP] ##1 release_pulse ##1 !flags[BIT_SETPOINT_OVERVOLT_TRIP]);
    c_two_word: cover property (@(posedge clk_i) disable iff (rst_i)
        (rd_req_i && rd_first_i && rd_addr_i == OFS_SECS_HI)
        ##1 (rd_req_i && rd_addr_i == OFS_SECS_LO));
    c_sticky: cover property (@(posedge clk_i) disable iff (rst_i)
        flags[BIT_EXTERNAL_SUPPLY_STOP] && !cause_i[BIT_EXTERNAL_SUPPLY_STOP]);
endmodule : sisr_bank

// file: verification/sisr_reader.sv
// Fieldbus client model reading the input registers of the bank
`timescale 1ns/100ps
module sisr_reader (
    // Clock
    input wire logic clk_i,
    // Read port towards the bank
    output logic rd_req_o,
    output logic rd_first_o,
    output logic [sisr_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic rd_err_i,
    input wire logic [sisr_pkg::DATA_W-1:0] rd_data_i
);
    import sisr_pkg::*;

    initial begin
        rd_req_o = 1'b0;
        rd_first_o = 1'b0;
        rd_addr_o = 16'h0000;
    end

    // Single word with idle gap; ok stays low if no answer comes
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e,
                      output logic ok);
        int i;
        ok = 1'b0;
        @(posedge clk_i);
        rd_req_o <= 1'b1;
        rd_first_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
        for (i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_ack_i === 1'b1) begin
                ok = 1'b1;
                e = rd_err_i;
                d = (a == OFS_STATUS) ? (rd_data_i & 16'h1FFF) : rd_data_i;
            end else begin
                @(posedge clk_i);
            end
        end
    endtask : rd

    // Back-to-back pair, high word first, second word from the snapshot
    task automatic rd32(input logic [15:0] a, output logic [31:0] v, output logic ok);
        logic [15:0] hi;
        @(posedge clk_i);
        rd_req_o <= 1'b1;
        rd_first_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge clk_i);
        rd_first_o <= 1'b0;
        rd_addr_o <= a + 16'h0001;
        #1;
        hi = rd_data_i;
        ok = (rd_ack_i === 1'b1);
        @(posedge clk_i);
        rd_req_o <= 1'b0;
        #1;
        ok = ok && (rd_ack_i === 1'b1);
        v = {hi, rd_data_i};
    endtask : rd32
endmodule : sisr_reader

// file: verification/tb_sisr_bank.sv
// Self-checking testbench of the supply input status register bank
`timescale 1ns/100ps
module tb_sisr_bank;
    import sisr_pkg::*;
    // Short second keeps the counter tests brief
    localparam int TK = 10;
    logic clk_i, rst_i, rd_req, rd_first, rd_ack, rd_err, e, ok;
    logic [12:0] cause_i, latch_mode_i;
    logic [2:0] warn_i;
    logic signed [15:0] volts_i, amps_i, temp_i;
    logic [15:0] rd_addr, rd_data, status, d;
    logic [31:0] nv_i, nv_o, v;
    int n_errors, check_count;
    logic [15:0] maddr [6];
    logic [15:0] mexp [6];

    sisr_bank #(.TICKS(TK)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cause_i(cause_i),
        .latch_mode_i(latch_mode_i), .warn_i(warn_i), .volts_i(volts_i), .amps_i(amps_i),
        .temp_i(temp_i), .nv_seconds_i(nv_i), .rd_req_i(rd_req), .rd_first_i(rd_first),
        .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_err_o(rd_err), .rd_data_o(rd_data),
        .status_o(status), .nv_seconds_o(nv_o));

    sisr_reader i_rdr (.clk_i(clk_i), .rd_req_o(rd_req), .rd_first_o(rd_first),
        .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_err_i(rd_err), .rd_data_i(rd_data));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic hung();
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: read not answered", $time);
            results();
        end
    endtask : hung

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // Cause levels are changed on the edge, then given time to settle
    task automatic cause(input int n, input logic val);
        @(posedge clk_i);
        cause_i[n] <= val;
        cyc(6);
    endtask : cause

    task automatic st(input logic [15:0] exp);
        i_rdr.rd(OFS_STATUS, d, e, ok);
        hung();
        chk({16'h0000, d}, {16'h0000, exp});
        chk({16'h0000, status & 16'h1FFF}, {16'h0000, exp});
    endtask : st

    task automatic cnt(input logic [15:0] a, input logic [31:0] exp);
        i_rdr.rd32(a, v, ok);
        hung();
        chk(v, exp);
    endtask : cnt

    initial begin
        rst_i = 1'b1;
        cause_i = 13'h0001;
        latch_mode_i = 13'h0000;
        warn_i = 3'h0;
        volts_i = 16'sh0000;
        amps_i = 16'sh0000;
        temp_i = 16'sh0000;
        nv_i = 32'h7FFFFFFD;
        n_errors = 0;
        check_count = 0;
        cyc(5);
        rst_i <= 1'b0;
        cyc(8);
        cnt(OFS_SECS_HI, 32'h7FFFFFFD);
        cyc(40);
        cnt(OFS_SECS_HI_ALIAS, 32'h7FFFFFFD);
        st(16'h0001);
        cause(0, 1'b0);
        cyc(60);
        cnt(OFS_SECS_HI, 32'h7FFFFFFF);
        $display("Test on-time counter done");
        maddr = '{OFS_VOLTS, OFS_VOLTS_ALIAS, OFS_AMPS, OFS_AMPS_ALIAS, OFS_TEMP,
                  OFS_TEMP_ALIAS};
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i);
            volts_i <= (s == 0) ? 16'sd4800 : 16'sd4000;
            amps_i <= (s == 0) ? 16'sd2000 : 16'sd4000;
            temp_i <= (s == 0) ? -16'sd320 : 16'sd1600;
            if (s == 0) begin
                mexp = '{16'h12C0, 16'h12C0, 16'h07D0, 16'h07D0, 16'hFEC0, 16'hFEC0};
            end else begin
                mexp = '{16'h0FA0, 16'h0FA0, 16'h0FA0, 16'h0FA0, 16'h0640, 16'h0640};
            end
            cyc(3);
            for (int k = 0; k < 6; k++) begin
                i_rdr.rd(maddr[k], d, e, ok);
                hung();
                chk({15'h0000, e, d}, {16'h0000, mexp[k]});
            end
        end
        $display("Test measurements done");
        for (int n = 1; n < 13; n++) begin
            if (n != 11) begin
                cause(n, 1'b1);
                st(16'h0001 << n);
                cause(n, 1'b0);
                st(16'h0000);
            end
        end
        $display("Test status bits done");
        @(posedge clk_i);
        latch_mode_i <= 13'h0030;
        cause(4, 1'b1);
        cause(5, 1'b1);
        cause(4, 1'b0);
        st(16'h0030);
        cause(0, 1'b1);
        st(16'h0031);
        cause(0, 1'b0);
        cause(5, 1'b0);
        st(16'h0030);
        cause(0, 1'b1);
        st(16'h0001);
        cause(0, 1'b0);
        st(16'h0000);
        $display("Test latching done");
        cause(11, 1'b1);
        cause(11, 1'b0);
        st(16'h0800);
        cause(0, 1'b1);
        cause(0, 1'b0);
        st(16'h0800);
        // Power cycle: retained count is fed back as at power up
        @(posedge clk_i);
        nv_i <= nv_o;
        rst_i <= 1'b1;
        cyc(5);
        rst_i <= 1'b0;
        cyc(8);
        st(16'h0000);
        cnt(OFS_SECS_HI_ALIAS, 32'h7FFFFFFF);
        $display("Test sticky bit and power cycle done");
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_i);
            warn_i <= (b < 3) ? (3'h1 << b) : 3'h0;
            cyc(6);
            i_rdr.rd(OFS_WARN, d, e, ok);
            hung();
            chk({16'h0000, d}, (b < 3) ? (32'h1 << b) : 32'h0);
        end
        i_rdr.rd(16'h0007, d, e, ok);
        hung();
        chk({15'h0000, e, d}, 32'h00010000);
        $display("Test warnings and unmapped read done");
        results();
    end
endmodule : tb_sisr_bank
